// file: design/time_base_and_watchdog.sv
// time base generator with supervisory counter behind a wishbone slave
// Contract
// [R1] 8-bit prescaler gives divide-by-2 to divide-by-256 clocks
// [R2] divided clocks change on falling clock edge
// [R3] reset clears prescaler, divided clocks low
// [R4] 12-bit supervisor counts selected time base ticks
// [R5] clock select 00..11 picks /32../256
// [R6] reset: control zero, supervisor stopped
// [R7] watchdog: 3C starts, C3 then 3C clears
// [R8] watchdog overflow asserts system reset output
// [R9] counting continues while processor halts
// [R10] mode 1, enable 0 stops counting
// [R11] mode back to 0 restarts from zero
// [R12] interval: 3C starts, later 3C clears
// [R13] interval overflow raises irq, no reset
// [R14] control updates only after 5A unlock write
// [R15] control update clears supervisor counter
// [R16] bit4 enable, bit3 mode, bits1:0 select
// [R17] supervisor count is never readable
// [R18] restart key is write-only 8-bit
// [R19] overflow after 4096 selected ticks
// [R20] clearing supervisor leaves prescaler running
// [R21] wrong key values neither start nor clear
`timescale 1ns/10ps
module time_base_and_watchdog #(
   parameter int SUPERVISOR_W = tbg_pkg::SUPERVISOR_W
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic wb_we,
   input wire logic [31:0] wb_adr,
   input wire logic [3:0] wb_sel,
   input wire logic [31:0] wb_dat_w,
   output logic [31:0] wb_dat_r,
   output logic wb_ack,
   output logic [tbg_pkg::PRESCALE_W-1:0] time_base_clk,
   output logic supervisor_reset_out,
   output logic interval_irq
);
   // ==========================================================
   // declarations
   logic [7:0] control_reg;
   logic unlock_reg;
   logic run_reg;
   logic [SUPERVISOR_W-1:0] count_reg;
   logic [tbg_pkg::PRESCALE_W-1:0] tick;
   logic [2:0] tap;
   logic tick_sel;
   logic request;
   logic commit;
   logic bus_write;
   logic hit_key;
   logic hit_ctrl;
   logic key_write;
   logic ctrl_write;
   logic ctrl_update;
   logic [7:0] ctrl_new;
   logic interval_mode_select;
   logic interval_enable;
   logic key_enable;
   logic start_pulse;
   logic clear_pulse;
   logic clear_any;
   logic overflow;
   tbg_pkg::key_state_type key_state;

   // ==========================================================
   // prescaler and key decoder
   prescale_divider #(
      .WIDTH(tbg_pkg::PRESCALE_W)
   ) u_prescale (
      .clk(clk),
      .reset(reset),
      .tick(tick),
      .time_base_clk(time_base_clk)
   );

   restart_key_sequencer u_keys (
      .clk(clk),
      .reset(reset),
      .resync(ctrl_update),
      .key_write(key_write && key_enable),
      .key_data(wb_dat_w[7:0]),
      .interval_mode(interval_mode_select),
      .running(run_reg),
      .start_pulse(start_pulse),
      .clear_pulse(clear_pulse),
      .key_state(key_state)
   );

   // ==========================================================
   // bus decode, writes take effect on the edge that sees ack
   assign request = wb_cyc && wb_stb;
   assign commit = request && wb_ack;
   assign bus_write = commit && wb_we && wb_sel[0];
   assign hit_key = wb_adr == tbg_pkg::RESTART_KEY_ADDR;
   assign hit_ctrl = wb_adr == tbg_pkg::CONTROL_ADDR;
   assign key_write = bus_write && hit_key; // [R18]
   assign ctrl_write = bus_write && hit_ctrl;
   assign ctrl_update = ctrl_write && unlock_reg; // [R14]
   assign ctrl_new = wb_dat_w[7:0] & tbg_pkg::CONTROL_MASK; // [R16]

   // ==========================================================
   // control fields
   assign interval_mode_select = control_reg[tbg_pkg::MODE_BIT];
   assign interval_enable = control_reg[tbg_pkg::IEN_BIT];
   assign key_enable = !(interval_mode_select && !interval_enable); // [R10]

   // ==========================================================
   // counting clock select
   assign tap = tbg_pkg::DIV32_TAP + {1'b0,
      control_reg[tbg_pkg::CKS_LSB +: tbg_pkg::CKS_W]}; // [R5]
   assign tick_sel = tick[tap]; // [R4]
   assign clear_any = ctrl_update || start_pulse || clear_pulse;
   assign overflow = run_reg && tick_sel && !clear_any &&
      (&count_reg); // [R19]

   // ==========================================================
   // bus acknowledge, one cycle after the request, then dropped
   always_ff @(posedge clk) begin
      if (reset) begin
         wb_ack <= 1'b0;
      end else begin
         wb_ack <= request && !wb_ack;
      end
   end

   // ==========================================================
   // read data, valid with ack; unmapped and key read as zero
   always_ff @(posedge clk) begin
      if (reset) begin
         wb_dat_r <= tbg_pkg::READ_IDLE;
      end else if (request && !wb_ack && !wb_we && hit_ctrl) begin
         wb_dat_r <= {24'h00_0000, control_reg}; // [R16] [R17]
      end else begin
         wb_dat_r <= tbg_pkg::READ_IDLE; // [R18]
      end
   end

   // ==========================================================
   // unlock latch, any other write disarms it
   always_ff @(posedge clk) begin
      if (reset) begin
         unlock_reg <= 1'b0;
      end else if (ctrl_write) begin
         unlock_reg <= !unlock_reg &&
            wb_dat_w[7:0] == tbg_pkg::KEY_UNLOCK; // [R14]
      end else if (bus_write) begin
         unlock_reg <= 1'b0; // [R14]
      end
   end

   // ==========================================================
   // control register
   always_ff @(posedge clk) begin
      if (reset) begin
         control_reg <= tbg_pkg::CONTROL_RESET; // [R6]
      end else if (ctrl_update) begin
         control_reg <= ctrl_new; // [R14]
      end
   end

   // ==========================================================
   // run state
   always_ff @(posedge clk) begin
      if (reset) begin
         run_reg <= 1'b0; // [R6]
      end else if (ctrl_update && ctrl_new[tbg_pkg::MODE_BIT]) begin
         // stays running only if already a running interval timer
         run_reg <= run_reg && interval_mode_select && interval_enable &&
            ctrl_new[tbg_pkg::IEN_BIT]; // [R10]
      end else if (ctrl_update) begin
         run_reg <= run_reg || interval_mode_select; // [R11]
      end else if (start_pulse) begin
         run_reg <= 1'b1; // [R7] [R12]
      end
   end

   // ==========================================================
   // supervisory counter, no halt input gates it
   always_ff @(posedge clk) begin
      if (reset) begin
         count_reg <= SUPERVISOR_W'(tbg_pkg::SUPERVISOR_ZERO);
      end else if (clear_any) begin
         // prescaler is untouched, so next tick may come early
         count_reg <= SUPERVISOR_W'(tbg_pkg::SUPERVISOR_ZERO); // [R15] [R20]
      end else if (run_reg && tick_sel) begin
         // [R4] [R9]
         count_reg <= count_reg + SUPERVISOR_W'(tbg_pkg::SUPERVISOR_STEP);
      end
   end

   // ==========================================================
   // overflow outputs
   always_ff @(posedge clk) begin
      if (reset) begin
         supervisor_reset_out <= 1'b0;
      end else if (overflow && !interval_mode_select) begin
         supervisor_reset_out <= 1'b1; // [R8]
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         interval_irq <= 1'b0;
      end else begin
         interval_irq <= overflow && interval_mode_select; // [R13]
      end
   end

   // ==========================================================
   // assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_wd_clear;
      clear_pulse && !interval_mode_select;
   endsequence

   sequence s_unlocked_update;
      ctrl_update && interval_mode_select && !ctrl_new[tbg_pkg::MODE_BIT];
   endsequence

   property p_prescale_step;
      !$past(reset) |->
         time_base_clk == $past(time_base_clk) + 8'h01;
   endproperty
   a_prescale_step: assert property (p_prescale_step) // [R1]
      else $error("prescaler outputs did not advance by one");

   property p_prescale_reset;
      disable iff (1'b0)
      reset |=> time_base_clk == 8'h00;
   endproperty
   a_prescale_reset: assert property (p_prescale_reset) // [R3]
      else $error("divided clocks not low after reset");

   property p_reset_state;
      disable iff (1'b0)
      reset |=> control_reg == tbg_pkg::CONTROL_RESET && !run_reg;
   endproperty
   a_reset_state: assert property (p_reset_state) // [R6]
      else $error("control or run state wrong after reset");

   property p_count_step;
      run_reg && tick_sel && !clear_any && !(&count_reg) |=>
         count_reg == $past(count_reg) +
         SUPERVISOR_W'(tbg_pkg::SUPERVISOR_STEP);
   endproperty
   a_count_step: assert property (p_count_step) // [R4]
      else $error("supervisor did not count a selected tick");

   // at the rising edge the divided clocks still show the prescale count
   property p_tap_select;
      tick_sel == ((time_base_clk | (8'he0 << control_reg[1:0])) == 8'hff);
   endproperty
   a_tap_select: assert property (p_tap_select) // [R5]
      else $error("wrong time base tap selected");

   property p_wd_clear;
      s_wd_clear |-> key_state == tbg_pkg::key_want_start
         ##1 count_reg == tbg_pkg::SUPERVISOR_ZERO;
   endproperty
   a_wd_clear: assert property (p_wd_clear) // [R7]
      else $error("watchdog clear without completed alternation");

   property p_wd_reset;
      overflow && !interval_mode_select |=> supervisor_reset_out [*2];
   endproperty
   a_wd_reset: assert property (p_wd_reset) // [R8]
      else $error("watchdog overflow did not hold system reset");

   property p_wd_hold;
      supervisor_reset_out |=> supervisor_reset_out;
   endproperty
   a_wd_hold: assert property (p_wd_hold) // [R8]
      else $error("system reset output dropped");

   property p_wd_start;
      !interval_mode_select && !run_reg && key_write &&
         wb_dat_w[7:0] == tbg_pkg::KEY_START |=>
         run_reg && count_reg == tbg_pkg::SUPERVISOR_ZERO;
   endproperty
   a_wd_start: assert property (p_wd_start) // [R7]
      else $error("watchdog start key ignored");

   property p_stopped;
      interval_mode_select && !interval_enable && !ctrl_update |->
         !run_reg ##1 count_reg == $past(count_reg);
   endproperty
   a_stopped: assert property (p_stopped) // [R10]
      else $error("supervisor counts while stopped");

   property p_resume;
      s_unlocked_update |=>
         run_reg && count_reg == tbg_pkg::SUPERVISOR_ZERO;
   endproperty
   a_resume: assert property (p_resume) // [R11]
      else $error("return to watchdog did not restart from zero");

   property p_interval_start;
      interval_mode_select && interval_enable && !run_reg && key_write &&
         wb_dat_w[7:0] == tbg_pkg::KEY_START |=> run_reg;
   endproperty
   a_interval_start: assert property (p_interval_start) // [R12]
      else $error("interval start key ignored");

   property p_interval_irq;
      overflow && interval_mode_select && !supervisor_reset_out |=>
         interval_irq && !supervisor_reset_out ##1 !interval_irq;
   endproperty
   a_interval_irq: assert property (p_interval_irq) // [R13]
      else $error("interval overflow handled wrongly");

   property p_locked_write;
      ctrl_write && !unlock_reg |=> control_reg == $past(control_reg);
   endproperty
   a_locked_write: assert property (p_locked_write) // [R14]
      else $error("control changed without unlock");

   property p_update_clears;
      ctrl_update |=> count_reg == tbg_pkg::SUPERVISOR_ZERO;
   endproperty
   a_update_clears: assert property (p_update_clears) // [R15]
      else $error("control update did not clear supervisor");

   property p_read_mask;
      wb_ack |-> (wb_dat_r & ~{24'h00_0000,
         tbg_pkg::CONTROL_MASK}) == tbg_pkg::READ_IDLE;
   endproperty
   a_read_mask: assert property (p_read_mask) // [R16]
      else $error("unimplemented control bits read nonzero");

   property p_key_reads_zero;
      request && !wb_we && hit_key && !wb_ack |=>
         wb_ack && wb_dat_r == tbg_pkg::READ_IDLE;
   endproperty
   a_key_reads_zero: assert property (p_key_reads_zero) // [R18]
      else $error("restart key location returned data");

   property p_bad_key;
      key_write && wb_dat_w[7:0] != tbg_pkg::KEY_START |->
         !start_pulse && !clear_pulse;
   endproperty
   a_bad_key: assert property (p_bad_key) // [R21]
      else $error("wrong key started or cleared supervisor");
endmodule // time_base_and_watchdog

// file: design/tbg_pkg.sv
// constants, types and register map of the time base and supervisor
package tbg_pkg;
   // ==========================================================
   // widths
   localparam int PRESCALE_W = 8;
   localparam int SUPERVISOR_W = 12;
   localparam int CKS_W = 2;

   // ==========================================================
   // register byte addresses
   localparam logic [31:0] RESTART_KEY_ADDR = 32'h0060_0200;
   localparam logic [31:0] CONTROL_ADDR = 32'h0060_0204;

   // ==========================================================
   // time base control layout
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] CONTROL_MASK = 8'h1b;
   localparam int IEN_BIT = 4;
   localparam int MODE_BIT = 3;
   localparam int CKS_LSB = 0;

   // ==========================================================
   // key values
   localparam logic [7:0] KEY_START = 8'h3c;
   localparam logic [7:0] KEY_ALT = 8'hc3;
   localparam logic [7:0] KEY_UNLOCK = 8'h5a;

   // ==========================================================
   // counting
   localparam logic [2:0] DIV32_TAP = 3'h4;
   localparam logic [11:0] SUPERVISOR_MAX = 12'hfff;
   localparam logic [11:0] SUPERVISOR_ZERO = 12'h000;
   localparam logic [11:0] SUPERVISOR_STEP = 12'h001;
   localparam logic [31:0] READ_IDLE = 32'h0000_0000;

   // ==========================================================
   // restart key sequence, gray coded
   typedef enum logic [1:0] {
      key_first = 2'b00,
      key_want_alt = 2'b01,
      key_want_start = 2'b11
   } key_state_type;
endpackage

// file: design/prescale_divider.sv
// free running prescale counter with binary divided clock outputs
`timescale 1ns/10ps
module prescale_divider #(
   parameter int WIDTH = tbg_pkg::PRESCALE_W
) (
   input wire logic clk,
   input wire logic reset,
   output logic [WIDTH-1:0] tick,
   output logic [WIDTH-1:0] time_base_clk
);
   logic [WIDTH-1:0] count_reg;

   // ==========================================================
   // counter
   always_ff @(posedge clk) begin
      if (reset) begin
         count_reg <= '0; // [R3]
      end else begin
         count_reg <= count_reg + WIDTH'(1); // [R1]
      end
   end

   // ==========================================================
   // one-cycle enables, tick[i] marks end of a divide by 2^(i+1)
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_tap
         assign tick[i] = &count_reg[i:0];
      end
   endgenerate

   // ==========================================================
   // outputs retimed so they move on the falling edge
   always_ff @(negedge clk) begin
      if (reset) begin
         time_base_clk <= '0; // [R3]
      end else begin
         time_base_clk <= count_reg; // [R2] [R1]
      end
   end
endmodule // prescale_divider

// file: design/restart_key_sequencer.sv
// decodes restart key writes into start and clear strobes
`timescale 1ns/10ps
module restart_key_sequencer (
   input wire logic clk,
   input wire logic reset,
   input wire logic resync,
   input wire logic key_write,
   input wire logic [7:0] key_data,
   input wire logic interval_mode,
   input wire logic running,
   output logic start_pulse,
   output logic clear_pulse,
   output tbg_pkg::key_state_type key_state
);
   tbg_pkg::key_state_type state_reg;
   tbg_pkg::key_state_type state_next;

   // ==========================================================
   // decode
   always_comb begin
      start_pulse = 1'b0;
      clear_pulse = 1'b0;
      state_next = state_reg;
      if (key_write && interval_mode) begin
         if (key_data == tbg_pkg::KEY_START) begin
            start_pulse = !running; // [R12]
            clear_pulse = running; // [R12]
         end
         state_next = tbg_pkg::key_first;
      end else if (key_write) begin
         case (state_reg)
            tbg_pkg::key_first: begin
               if (key_data == tbg_pkg::KEY_START && !running) begin
                  start_pulse = 1'b1; // [R7]
                  state_next = tbg_pkg::key_want_alt;
               end else if (key_data == tbg_pkg::KEY_ALT && running) begin
                  state_next = tbg_pkg::key_want_start;
               end
            end
            tbg_pkg::key_want_alt: begin
               if (key_data == tbg_pkg::KEY_ALT) begin
                  state_next = tbg_pkg::key_want_start; // [R7]
               end
            end
            tbg_pkg::key_want_start: begin
               if (key_data == tbg_pkg::KEY_START) begin
                  clear_pulse = 1'b1; // [R7]
                  state_next = tbg_pkg::key_want_alt;
               end
            end
            default: begin
               state_next = tbg_pkg::key_first;
            end
         endcase
      end
      if (resync) begin
         state_next = tbg_pkg::key_first;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg <= tbg_pkg::key_first;
      end else begin
         state_reg <= state_next; // [R21]
      end
   end

   assign key_state = state_reg;
endmodule // restart_key_sequencer

// file: tb/time_base_and_watchdog_bench.sv
// self-checking bench for the time base and supervisory counter block
`timescale 1ns/10ps
module time_base_and_watchdog_bench;
   // ==========================================================
   // signals
   logic clk;
   logic reset;
   logic wb_cyc;
   logic wb_stb;
   logic wb_we;
   logic [31:0] wb_adr;
   logic [3:0] wb_sel;
   logic [31:0] wb_dat_w;
   logic [31:0] wb_dat_r;
   logic wb_ack;
   logic [tbg_pkg::PRESCALE_W-1:0] time_base_clk;
   logic supervisor_reset_out;
   logic interval_irq;
   int fails = 0;
   int n_checks = 0;
   int cycle = 0;
   logic [31:0] rnd = 32'h31ae9cd4;
   logic [31:0] exp_q[$];
   logic [7:0] pc = 8'h00;
   logic [7:0] pc_prev = 8'h00;
   logic [7:0] v;
   int t0;
   int d;
   // narrow supervisor keeps the run short; span is 32 * 2^SW cycles
   localparam int SW = 8;
   localparam int SPAN = 32 * (1 << SW);

   time_base_and_watchdog #(
      .SUPERVISOR_W(SW)
   ) dut_u (
      .clk(clk),
      .reset(reset),
      .wb_cyc(wb_cyc),
      .wb_stb(wb_stb),
      .wb_we(wb_we),
      .wb_adr(wb_adr),
      .wb_sel(wb_sel),
      .wb_dat_w(wb_dat_w),
      .wb_dat_r(wb_dat_r),
      .wb_ack(wb_ack),
      .time_base_clk(time_base_clk),
      .supervisor_reset_out(supervisor_reset_out),
      .interval_irq(interval_irq)
   );

   // ==========================================================
   // helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h00000000);
   endfunction

   task automatic check(input string name, input logic [31:0] exp,
                        input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic print_verdict();
      if (fails == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // one classic cycle, held until ack is sampled high
   task automatic bus(input logic we, input logic [31:0] adr,
                      input logic [7:0] dat, input logic [3:0] sel);
      int n;
      rnd = lfsr(rnd);
      @(posedge clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_sel <= sel;
      wb_dat_w <= {rnd[31:8], dat};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 50);
      check("bus ack", 32'h1, {31'h0, wb_ack});
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask

   task automatic wr(input logic [31:0] adr, input logic [7:0] dat);
      bus(1'b1, adr, dat, 4'h1);
   endtask

   task automatic rd(input logic [31:0] adr, input logic [31:0] exp);
      exp_q.push_back(exp);
      bus(1'b0, adr, 8'h00, 4'hf);
   endtask

   // waits for either overflow output, span counted from t0
   task automatic wait_overflow(input string name);
      int n;
      n = 0;
      while (interval_irq !== 1'b1 && supervisor_reset_out !== 1'b1 &&
             n < SPAN + 100) begin
         @(posedge clk);
         n++;
      end
      d = cycle - t0;
      n_checks++;
      if (d < SPAN - 32 || d > SPAN + 3) begin
         fails++;
         $display("wrong value %s expected %0d seen %0d", name, SPAN, d);
      end
   endtask

   task automatic ctl(input logic [7:0] val);
      wr(tbg_pkg::CONTROL_ADDR, tbg_pkg::KEY_UNLOCK);
      wr(tbg_pkg::CONTROL_ADDR, val);
   endtask

   // ==========================================================
   // clock, monitors, watchdog
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      cycle <= cycle + 1;
      pc_prev <= pc;
      pc <= reset ? 8'h00 : pc + 8'h01;
   end

   // divided clocks must still show the older count at each falling edge
   always @(negedge clk) begin
      if (cycle > 3 && !reset) begin
         check("time base clocks", {24'h0, pc_prev}, {24'h0, time_base_clk});
      end
   end

   always @(posedge clk) begin
      if (wb_ack === 1'b1 && wb_we === 1'b0) begin
         if (exp_q.size() == 0) begin
            check("unexpected read", 32'h0, 32'h1);
         end else begin
            check("read data", exp_q.pop_front(), wb_dat_r);
         end
      end
   end

   initial begin
      repeat (30000) @(posedge clk);
      fails++;
      print_verdict();
   end

   // ==========================================================
   // main sequence
   initial begin
      reset = 1'b1;
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      wb_we = 1'b0;
      wb_adr = 32'h0;
      wb_sel = 4'h0;
      wb_dat_w = 32'h0;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      check("reset out", 32'h0, {31'h0, supervisor_reset_out});
      check("irq", 32'h0, {31'h0, interval_irq});
      rd(tbg_pkg::CONTROL_ADDR, {24'h0, tbg_pkg::CONTROL_RESET});
      rd(tbg_pkg::RESTART_KEY_ADDR, tbg_pkg::READ_IDLE);
      rd(32'h0060_0208, tbg_pkg::READ_IDLE);
      // writes without a directly preceding unlock are dropped
      wr(tbg_pkg::CONTROL_ADDR, 8'h1b);
      rd(tbg_pkg::CONTROL_ADDR, 32'h0);
      wr(tbg_pkg::CONTROL_ADDR, tbg_pkg::KEY_UNLOCK);
      wr(tbg_pkg::RESTART_KEY_ADDR, 8'h77);
      wr(tbg_pkg::CONTROL_ADDR, 8'h1b);
      rd(tbg_pkg::CONTROL_ADDR, 32'h0);
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         v = (rnd[7:0] & 8'hfc) | 8'(i);
         ctl(v);
         rd(tbg_pkg::CONTROL_ADDR, {24'h0, v & tbg_pkg::CONTROL_MASK});
      end
      ctl(8'h18);
      rd(tbg_pkg::CONTROL_ADDR, 32'h18);
      wr(tbg_pkg::RESTART_KEY_ADDR, tbg_pkg::KEY_START);
      repeat (1000) @(posedge clk);
      wr(tbg_pkg::RESTART_KEY_ADDR, tbg_pkg::KEY_START);
      t0 = cycle;
      repeat (4000) @(posedge clk);
      // none of these may clear the running interval counter
      wr(tbg_pkg::RESTART_KEY_ADDR, tbg_pkg::KEY_ALT);
      rnd = lfsr(rnd);
      v = (rnd[7:0] == tbg_pkg::KEY_START) ? 8'h00 : rnd[7:0];
      wr(tbg_pkg::RESTART_KEY_ADDR, v);
      wr(tbg_pkg::CONTROL_ADDR, 8'h18);
      rd(tbg_pkg::RESTART_KEY_ADDR, tbg_pkg::READ_IDLE);
      wait_overflow("interval overflow");
      @(posedge clk);
      check("irq pulse", 32'h0, {31'h0, interval_irq});
      check("reset out", 32'h0, {31'h0, supervisor_reset_out});
      // back to watchdog: auto restart, alternation, then update clear
      ctl(8'h00);
      wr(tbg_pkg::RESTART_KEY_ADDR, tbg_pkg::KEY_ALT);
      wr(tbg_pkg::RESTART_KEY_ADDR, tbg_pkg::KEY_START);
      repeat (3000) @(posedge clk);
      ctl(8'h00);
      t0 = cycle;
      wait_overflow("watchdog overflow");
      check("reset out", 32'h1, {31'h0, supervisor_reset_out});
      check("irq", 32'h0, {31'h0, interval_irq});
      repeat (3) @(posedge clk);
      check("reset held", 32'h1, {31'h0, supervisor_reset_out});
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      check("reset out", 32'h0, {31'h0, supervisor_reset_out});
      rd(tbg_pkg::CONTROL_ADDR, {24'h0, tbg_pkg::CONTROL_RESET});
      wr(tbg_pkg::RESTART_KEY_ADDR, tbg_pkg::KEY_START);
      print_verdict();
   end
endmodule // time_base_and_watchdog_bench
